// ==== src/btr_regs.svh ====
// Register offsets, field values and reset values of the trigger and clock router
`ifndef BTR_REGS_SVH
`define BTR_REGS_SVH
`define BTR_ADDR_W 16
`define BTR_OFS_REFCLK 16'h4EAC
`define BTR_OFS_TRGOUT 16'h9D6C
`define BTR_OFS_TRGOUT_AVAIL 16'h9D6D
`define BTR_OFS_TRGIN 16'h9D6E
`define BTR_OFS_CTRL 16'h9D70
`define BTR_OFS_STATUS 16'h9D71
`define BTR_REF_INTERNAL 32'h00000000
`define BTR_REF_BACKPLANE 32'hFFFFFFFF
`define BTR_OUT_OFF 4'h0
`define BTR_OUT_LINE0 4'h1
`define BTR_OUT_LINE5 4'h6
`define BTR_OUT_STAR 4'h9
`define BTR_AVAIL_VALUE 16'h013F
`define BTR_TRGIN_MASK 16'h013F
`define BTR_STAR_BIT 8
`define BTR_READY_LINE 7
`define BTR_CTRL_ARMED_BIT 0
`define BTR_CTRL_PRE_DONE_BIT 1
`define BTR_ZERO32 32'h00000000
`endif

// ==== src/btr_pkg.sv ====
// Types of the trigger and clock router
package btr_pkg;
  typedef enum logic [2:0] {
    BTR_IDLE = 3'b001,
    BTR_HIGH = 3'b010,
    BTR_DONE = 3'b100
  } btr_pulse_state_t;
endpackage

// ==== src/btr_ref_mux.sv ====
// Sample clock reference selector feeding the PLL
`timescale 1ns/1ps
module btr_ref_mux (
  input wire logic use_backplane,
  input wire logic internal_ref,
  input wire logic backplane_ref,
  output logic pll_ref
);
  assign pll_ref = use_backplane ? backplane_ref : internal_ref;
endmodule // btr_ref_mux

// ==== src/btr_line_drv.sv ====
// Registered tri-state driver for one backplane trigger line
`timescale 1ns/1ps
module btr_line_drv (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic selected,
  input wire logic level,
  output logic line_out,
  output logic line_oe
);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      line_out <= 1'b0;
      line_oe <= 1'b0;
    end else begin
      line_out <= level;
      line_oe <= selected;
    end
  end
endmodule // btr_line_drv

// ==== src/btr_router.sv ====
// Backplane trigger and reference clock router
// How it works
// - Reference select: 0 internal, -1 backplane
// - Backplane 10 MHz clock feeds the PLL
// - Programmed output diverts own trigger to line
// - Rising edge marks trigger; low at stop
// - Output select: 0 off, 1-6 lines, 9 star
// - Read-only bitmap of usable output lines
// - Line 7 shows pretrigger elapsed, ready
// - Line 7 open collector, wired AND
// - No input to output trigger path
// - Lines undriven after reset until programmed
// - Selected input lines ORed into trigger
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "btr_regs.svh"
module btr_router #(
  parameter int NUM_LINES = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic internal_ref,
  input wire logic backplane_ref,
  output logic pll_ref,
  output logic ref_is_backplane,
  input wire logic own_trigger,
  input wire logic acquiring,
  input wire logic pretrigger_done,
  output logic self_trigger,
  input wire logic [7:0] trig_line_in,
  output logic [7:0] trig_line_out,
  output logic [7:0] trig_line_oe,
  input wire logic star_in,
  output logic star_out,
  output logic star_oe,
  output logic trigger_enable
);
  // ***************************************
  // Registers
  // ***************************************
  logic [31:0] refsel_q;
  logic [3:0] outsel_q;
  logic [15:0] insel_q;
  logic armed_q;
  logic [31:0] rdata_q;
  btr_pkg::btr_pulse_state_t state_q;
  logic trig_prev_q;
  logic pulse_q;

  function automatic logic sel_is_line(input logic [3:0] sel, input int idx);
    sel_is_line = (sel >= `BTR_OUT_LINE0) && (sel <= `BTR_OUT_LINE5) &&
                  (sel - `BTR_OUT_LINE0 == 4'(idx));
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refsel_q <= `BTR_REF_INTERNAL;
    end else if (wr && addr == `BTR_OFS_REFCLK) begin
      if (wdata == `BTR_REF_BACKPLANE) begin
        refsel_q <= `BTR_REF_BACKPLANE;
      end else begin
        refsel_q <= `BTR_REF_INTERNAL;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      outsel_q <= `BTR_OUT_OFF;
    end else if (wr && addr == `BTR_OFS_TRGOUT) begin
      if ((wdata[3:0] <= `BTR_OUT_LINE5 || wdata[3:0] == `BTR_OUT_STAR) && wdata[31:4] == 28'h0000000) begin
        outsel_q <= wdata[3:0];
      end else begin
        outsel_q <= `BTR_OUT_OFF;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      insel_q <= 16'h0000;
    end else if (wr && addr == `BTR_OFS_TRGIN) begin
      insel_q <= wdata[15:0] & `BTR_TRGIN_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
    end else if (wr && addr == `BTR_OFS_CTRL) begin
      armed_q <= wdata[`BTR_CTRL_ARMED_BIT];
    end
  end

  // ***************************************
  // Read port
  // ***************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= `BTR_ZERO32;
    end else if (rd) begin
      case (addr)
        `BTR_OFS_REFCLK: rdata_q <= refsel_q;
        `BTR_OFS_TRGOUT: rdata_q <= {28'h0000000, outsel_q};
        `BTR_OFS_TRGOUT_AVAIL: rdata_q <= {16'h0000, `BTR_AVAIL_VALUE};
        `BTR_OFS_TRGIN: rdata_q <= {16'h0000, insel_q};
        `BTR_OFS_CTRL: rdata_q <= {31'h00000000, armed_q};
        `BTR_OFS_STATUS: rdata_q <= {29'h00000000, trigger_enable, pretrigger_done, pulse_q};
        default: rdata_q <= `BTR_ZERO32;
      endcase
    end else begin
      rdata_q <= `BTR_ZERO32;
    end
  end
  assign rdata = rdata_q;

  // ***************************************
  // Reference clock
  // ***************************************
  assign ref_is_backplane = (refsel_q == `BTR_REF_BACKPLANE);

  btr_ref_mux u_ref (
    .use_backplane(ref_is_backplane),
    .internal_ref(internal_ref),
    .backplane_ref(backplane_ref),
    .pll_ref(pll_ref)
  );

  // ***************************************
  // Trigger output pulse
  // ***************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= own_trigger;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= btr_pkg::BTR_IDLE;
      pulse_q <= 1'b0;
    end else begin
      case (state_q)
        btr_pkg::BTR_IDLE: begin
          if (acquiring && own_trigger && !trig_prev_q) begin
            state_q <= btr_pkg::BTR_HIGH;
            pulse_q <= 1'b1;
          end
        end
        btr_pkg::BTR_HIGH: begin
          if (!acquiring) begin
            state_q <= btr_pkg::BTR_IDLE;
            pulse_q <= 1'b0;
          end else begin
            state_q <= btr_pkg::BTR_DONE;
          end
        end
        btr_pkg::BTR_DONE: begin
          if (!acquiring) begin
            state_q <= btr_pkg::BTR_IDLE;
            pulse_q <= 1'b0;
          end
        end
        default: begin
          state_q <= btr_pkg::BTR_IDLE;
          pulse_q <= 1'b0;
        end
      endcase
    end
  end

  // ***************************************
  // Backplane lines
  // ***************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      btr_line_drv u_drv (
        .clk(clk),
        .reset_n(reset_n),
        .selected(sel_is_line(outsel_q, gi)),
        .level(pulse_q),
        .line_out(trig_line_out[gi]),
        .line_oe(trig_line_oe[gi])
      );
    end
  endgenerate

  btr_line_drv u_star (
    .clk(clk),
    .reset_n(reset_n),
    .selected(outsel_q == `BTR_OUT_STAR),
    .level(pulse_q),
    .line_out(star_out),
    .line_oe(star_oe)
  );

  assign trig_line_out[6] = 1'b0;
  assign trig_line_oe[6] = 1'b0;
  // Pull low while armed until pretrigger elapsed; release otherwise
  assign trig_line_out[`BTR_READY_LINE] = 1'b0;
  assign trig_line_oe[`BTR_READY_LINE] = armed_q && !pretrigger_done;
  assign trigger_enable = trig_line_in[`BTR_READY_LINE];

  // ***************************************
  // Trigger to own acquisition
  // ***************************************
  logic [15:0] in_vec;
  assign in_vec = {7'h00, star_in, 2'h0, trig_line_in[5:0]};
  assign self_trigger = (outsel_q == `BTR_OUT_OFF) ?
                        (((in_vec & insel_q) != 16'h0000) || (insel_q == 16'h0000 && own_trigger)) :
                        ((in_vec & insel_q) != 16'h0000);
endmodule // btr_router

// ==== verification/btr_bus_model.sv ====
// Other cards sharing the backplane trigger lines
`timescale 1ns/1ps
module btr_bus_model (
  input wire logic [7:0] trig_line_out,
  input wire logic [7:0] trig_line_oe,
  input wire logic star_out,
  input wire logic star_oe,
  input wire logic [8:0] p_en,
  input wire logic [8:0] p_val,
  output logic [7:0] trig_line_in,
  output logic star_in
);
  logic [8:0] o, e, l;
  assign o = {star_out, trig_line_out};
  assign e = {star_oe, trig_line_oe};
  // Pull-up on released lines, wired AND on line 7
  assign l = (e & o) | (~e & ((p_en & p_val) | ~p_en));
  assign trig_line_in = l[7:0];
  assign star_in = l[8];
endmodule // btr_bus_model

// ==== verification/btr_router_checker.sv ====
// Port assertions of the trigger and clock router
`timescale 1ns/1ps
module btr_router_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic internal_ref,
  input wire logic backplane_ref,
  input wire logic pll_ref,
  input wire logic ref_is_backplane,
  input wire logic acquiring,
  input wire logic pretrigger_done,
  input wire logic [7:0] trig_line_out,
  input wire logic [7:0] trig_line_oe,
  input wire logic star_out,
  input wire logic star_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_int; !ref_is_backplane |-> pll_ref == internal_ref; endproperty
  a_int: assert property (p_int) else $error("ref not internal");
  property p_bp; ref_is_backplane |-> pll_ref == backplane_ref; endproperty
  a_bp: assert property (p_bp) else $error("ref not backplane");
  property p_oc; trig_line_oe[7] |-> !trig_line_out[7]; endproperty
  a_oc: assert property (p_oc) else $error("line 7 driven high");
  property p_rdy; pretrigger_done |-> !trig_line_oe[7]; endproperty
  a_rdy: assert property (p_rdy) else $error("line 7 held after ready");
  property p_six; !trig_line_oe[6]; endproperty
  a_six: assert property (p_six) else $error("line 6 driven");
  property p_stop; !acquiring [*2] |=> {trig_line_out[5:0], star_out} == 7'h00; endproperty
  a_stop: assert property (p_stop) else $error("trigger high after stop");
  property p_hiz; $rose(reset_n) |-> trig_line_oe == 8'h00 && !star_oe; endproperty
  a_hiz: assert property (p_hiz) else $error("line driven after reset");
  property p_one; $onehot0({star_oe, trig_line_oe[5:0]}); endproperty
  a_one: assert property (p_one) else $error("several outputs driven");
endmodule // btr_router_checker
bind btr_router btr_router_checker u_chk (.clk, .reset_n, .internal_ref, .backplane_ref,
  .pll_ref, .ref_is_backplane, .acquiring, .pretrigger_done, .trig_line_out, .trig_line_oe,
  .star_out, .star_oe);

// ==== verification/tb_top.sv ====
// Self-checking bench of the trigger and clock router
`timescale 1ns/1ps
`include "btr_regs.svh"
module tb_top;
  logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, own_trigger = 1'b0;
  logic internal_ref = 1'b0, backplane_ref = 1'b0, acquiring = 1'b0, pretrigger_done = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h00000000, rdata;
  // Other cards stay off lines this card drives, except line 7
  logic [8:0] p_en = 9'h000, p_val = 9'h000;
  logic pll_ref, ref_is_backplane, self_trigger, star_in, star_out, star_oe, trigger_enable;
  logic [7:0] trig_line_in, trig_line_out, trig_line_oe;
  int errors = 0;
  int check_count = 0;
  initial forever #50 clk = ~clk;
  always @(posedge clk) internal_ref <= ~internal_ref;
  always @(posedge clk) if (internal_ref) backplane_ref <= ~backplane_ref;
  btr_router DUT (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .internal_ref,
    .backplane_ref, .pll_ref, .ref_is_backplane, .own_trigger, .acquiring, .pretrigger_done,
    .self_trigger, .trig_line_in, .trig_line_out, .trig_line_oe, .star_in, .star_out,
    .star_oe, .trigger_enable);
  btr_bus_model u_bus (.trig_line_out, .trig_line_oe, .star_out, .star_oe, .p_en, .p_val,
    .trig_line_in, .star_in);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic test_done();
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    tick(1);
    chk(32'(trig_line_oe), 32'h0);
    rd_reg(`BTR_OFS_REFCLK, 32'h0);
    wr_reg(`BTR_OFS_TRGOUT_AVAIL, 32'h0);
    rd_reg(`BTR_OFS_TRGOUT_AVAIL, 32'h0000013F);
    rd_reg(16'h1234, 32'h0);
    wr_reg(`BTR_OFS_REFCLK, 32'hFFFFFFFF);
    rd_reg(`BTR_OFS_REFCLK, 32'hFFFFFFFF);
    chk(32'(ref_is_backplane), 32'h1);
    wr_reg(`BTR_OFS_REFCLK, 32'h5);
    rd_reg(`BTR_OFS_REFCLK, 32'h0);
    for (int v = 0; v < 11; v++) begin
      wr_reg(`BTR_OFS_TRGOUT, 32'(v));
      tick(2);
      chk({23'h0, star_oe, trig_line_oe},
          v == 9 ? 32'h100 : (v >= 1 && v <= 6) ? 32'h1 << (v - 1) : 32'h0);
      rd_reg(`BTR_OFS_TRGOUT, v < 7 || v == 9 ? 32'(v) : 32'h0);
    end
    wr_reg(`BTR_OFS_TRGOUT, 32'h2);
    p_en <= 9'h001;
    p_val <= 9'h001;
    acquiring <= 1'b1;
    own_trigger <= 1'b1;
    tick(1);
    chk(32'(trig_line_out[1]), 32'h0);
    tick(2);
    chk({trig_line_out[1], trig_line_oe, self_trigger}, 32'h204);
    @(posedge clk);
    acquiring <= 1'b0;
    tick(3);
    chk(32'(trig_line_out[1]), 32'h0);
    wr_reg(`BTR_OFS_TRGOUT, 32'h0);
    wr_reg(`BTR_OFS_TRGIN, 32'h0000FF00);
    p_en <= 9'h17F;
    p_val <= 9'h07F;
    rd_reg(`BTR_OFS_TRGIN, 32'h100);
    chk(32'(self_trigger), 32'h0);
    @(posedge clk);
    p_val <= 9'h100;
    tick(1);
    chk(32'(self_trigger), 32'h1);
    wr_reg(`BTR_OFS_CTRL, 32'h1);
    p_en <= 9'h080;
    p_val <= 9'h000;
    tick(2);
    chk({trig_line_oe[7], trig_line_out[7], trigger_enable}, 32'h4);
    @(posedge clk);
    pretrigger_done <= 1'b1;
    tick(1);
    chk({trig_line_oe[7], trigger_enable}, 32'h0);
    @(posedge clk);
    p_en <= 9'h000;
    tick(1);
    chk(32'(trigger_enable), 32'h1);
    rd_reg(`BTR_OFS_CTRL, 32'h1);
    rd_reg(`BTR_OFS_STATUS, 32'h6);
    wr_reg(`BTR_OFS_TRGIN, 32'h0);
    tick(1);
    chk(32'(self_trigger), 32'h1);
    @(posedge clk);
    own_trigger <= 1'b0;
    tick(1);
    chk(32'(self_trigger), 32'h0);
    wr_reg(`BTR_OFS_TRGOUT, 32'h9);
    acquiring <= 1'b1;
    own_trigger <= 1'b1;
    tick(2);
    chk({star_out, star_oe, self_trigger}, 32'h6);
    rd_reg(`BTR_OFS_STATUS, 32'h7);
    @(posedge clk);
    acquiring <= 1'b0;
    tick(3);
    chk(32'(star_out), 32'h0);
    test_done();
  end
endmodule // tb_top
